// File: core/sjt_tap.sv
// Boundary-scan test access port of the SRAM, sampled on the system clock
`timescale 1ns/1ns
module sjt_tap #(
   // Arbitrary neutral identification value, bit 0 fixed high
   parameter logic [31:0] ID_CODE = 32'h0a5c_3001
) (
   input  wire logic                        sys_clk_i,
   input  wire logic                        arst_n_i,
   input  wire logic                        tck_i,
   input  wire logic                        tms_i,
   input  wire logic                        tdi_i,
   input  wire logic [sjt_pkg::BSR_LEN-1:0] ring_i,
   output logic                             tdo_o,
   output logic                             tdo_oe_o
);

   //===========================================================================
   // Declarations
   logic [2:0]                  pin_s;
   logic                        tck_s;
   logic                        tms_s;
   logic                        tdi_s;
   logic [sjt_pkg::BSR_LEN-1:0] ring_s;
   logic                        tck_d_q;
   logic                        tck_rise;
   logic                        tck_fall;
   logic                        rise_pend_q;
   logic                        tms_smp_q;
   logic                        tdi_smp_q;
   logic                        proc;
   sjt_pkg::sjt_state_e         state_q;
   sjt_pkg::sjt_state_e         state_nx;
   logic [sjt_pkg::IR_W-1:0]    ir_sh_q;
   logic [sjt_pkg::IR_W-1:0]    ir_act_q;
   logic                        byp_q;
   logic [sjt_pkg::ID_W-1:0]    id_sh_q;
   logic [sjt_pkg::BSR_LEN-1:0] bsr_q;
   logic                        sel_id;
   logic                        sel_bsr;
   logic                        scan_lsb;
   logic                        push_q;
   logic                        buf_in_ready;
   logic                        buf_out_valid;
   logic [1:0]                  buf_out_data;
   logic [2:0]                  tms_ones_q;
   logic                        tdo_q;
   logic                        tdo_oe_q;

   //===========================================================================
   // Controller next state; mode select is the only steering input
   function automatic sjt_pkg::sjt_state_e next_state(input sjt_pkg::sjt_state_e st,
                                                      input logic tms);
      case (st)
         sjt_pkg::ST_TLR:   return tms ? sjt_pkg::ST_TLR   : sjt_pkg::ST_RTI;
         sjt_pkg::ST_RTI:   return tms ? sjt_pkg::ST_SELDR : sjt_pkg::ST_RTI;
         sjt_pkg::ST_SELDR: return tms ? sjt_pkg::ST_SELIR : sjt_pkg::ST_CAPDR;
         sjt_pkg::ST_CAPDR: return tms ? sjt_pkg::ST_EX1DR : sjt_pkg::ST_SHDR;
         sjt_pkg::ST_SHDR:  return tms ? sjt_pkg::ST_EX1DR : sjt_pkg::ST_SHDR;
         sjt_pkg::ST_EX1DR: return tms ? sjt_pkg::ST_UPDR  : sjt_pkg::ST_PADR;
         sjt_pkg::ST_PADR:  return tms ? sjt_pkg::ST_EX2DR : sjt_pkg::ST_PADR;
         sjt_pkg::ST_EX2DR: return tms ? sjt_pkg::ST_UPDR  : sjt_pkg::ST_SHDR;
         sjt_pkg::ST_UPDR:  return tms ? sjt_pkg::ST_SELDR : sjt_pkg::ST_RTI;
         sjt_pkg::ST_SELIR: return tms ? sjt_pkg::ST_TLR   : sjt_pkg::ST_CAPIR;
         sjt_pkg::ST_CAPIR: return tms ? sjt_pkg::ST_EX1IR : sjt_pkg::ST_SHIR;
         sjt_pkg::ST_SHIR:  return tms ? sjt_pkg::ST_EX1IR : sjt_pkg::ST_SHIR;
         sjt_pkg::ST_EX1IR: return tms ? sjt_pkg::ST_UPIR  : sjt_pkg::ST_PAIR;
         sjt_pkg::ST_PAIR:  return tms ? sjt_pkg::ST_EX2IR : sjt_pkg::ST_PAIR;
         sjt_pkg::ST_EX2IR: return tms ? sjt_pkg::ST_UPIR  : sjt_pkg::ST_SHIR;
         sjt_pkg::ST_UPIR:  return tms ? sjt_pkg::ST_SELDR : sjt_pkg::ST_RTI;
         default:           return sjt_pkg::ST_TLR;
      endcase
   endfunction : next_state

   //===========================================================================
   // Pin synchronisers; the test clock is just another sampled level
   sjt_sync #(
      .WIDTH (3)
   ) u_pin_sync (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .async_i   ({tck_i, tms_i, tdi_i}),
      .sync_o    (pin_s)
   );

   // Ring cells come from pads, so they are synchronised too
   sjt_sync #(
      .WIDTH (sjt_pkg::BSR_LEN)
   ) u_ring_sync (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .async_i   (ring_i),
      .sync_o    (ring_s)
   );

   assign tck_s = pin_s[2];
   assign tms_s = pin_s[1];
   assign tdi_s = pin_s[0];

   //===========================================================================
   // Test clock edge detection
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tck_d_q <= 1'b0;
      end else begin
         tck_d_q <= tck_s;
      end
   end

   assign tck_rise = tck_s && !tck_d_q; // RL1
   assign tck_fall = !tck_s && tck_d_q; // RL1

   // Inputs frozen at the rising edge, so a late step still sees them
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tms_smp_q <= 1'b1;
         tdi_smp_q <= 1'b0;
      end else if (tck_rise) begin
         tms_smp_q <= tms_s; // RL1
         tdi_smp_q <= tdi_s; // RL1
      end
   end

   // Pending step; a new edge wins over the clear of the old one
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rise_pend_q <= 1'b0;
      end else if (tck_rise) begin
         rise_pend_q <= 1'b1;
      end else if (proc) begin
         rise_pend_q <= 1'b0;
      end
   end

   // A full output buffer stalls the step instead of dropping a bit
   assign proc     = rise_pend_q && buf_in_ready && !push_q;
   assign state_nx = next_state(state_q, tms_smp_q);

   //===========================================================================
   // Controller state; power-up lands in reset, no reset pin exists
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= sjt_pkg::ST_TLR; // RL7 RL5
      end else if (proc) begin
         state_q <= state_nx; // RL2 RL18 RL6
      end
   end

   //===========================================================================
   // Instruction register: shift stage and active stage
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ir_sh_q  <= sjt_pkg::INS_IDCODE; // RL10
         ir_act_q <= sjt_pkg::INS_IDCODE; // RL10
      end else if (proc) begin
         if (state_nx == sjt_pkg::ST_TLR) begin
            ir_sh_q  <= sjt_pkg::INS_IDCODE; // RL10
            ir_act_q <= sjt_pkg::INS_IDCODE; // RL10
         end else if (state_q == sjt_pkg::ST_CAPIR) begin
            ir_sh_q <= sjt_pkg::IR_CAPTURE; // RL9
         end else if (state_q == sjt_pkg::ST_SHIR) begin
            ir_sh_q <= {tdi_smp_q, ir_sh_q[sjt_pkg::IR_W-1:1]}; // RL9
         end else if (state_q == sjt_pkg::ST_UPIR) begin
            // Takes effect from idle or the data path states onward
            ir_act_q <= ir_sh_q; // RL8
         end
      end
   end

   // Data register selection from the active instruction
   assign sel_id  = (ir_act_q == sjt_pkg::INS_IDCODE);
   assign sel_bsr = sjt_pkg::sjt_sel_bsr(ir_act_q); // RL16

   //===========================================================================
   // Bypass stage
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         byp_q <= 1'b0;
      end else if (proc && !sel_id && !sel_bsr) begin
         if (state_q == sjt_pkg::ST_CAPDR) begin
            byp_q <= 1'b0;
         end else if (state_q == sjt_pkg::ST_SHDR) begin
            byp_q <= tdi_smp_q; // RL11
         end
      end
   end

   // Identification register
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         id_sh_q <= '0;
      end else if (proc && sel_id) begin
         if (state_q == sjt_pkg::ST_CAPDR) begin
            id_sh_q <= ID_CODE; // RL12
         end else if (state_q == sjt_pkg::ST_SHDR) begin
            id_sh_q <= {tdi_smp_q, id_sh_q[sjt_pkg::ID_W-1:1]}; // RL13
         end
      end
   end

   // Boundary register; bit k is bump position k+1, shifted out first
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bsr_q <= '0;
      end else if (proc && sel_bsr) begin
         if (state_q == sjt_pkg::ST_CAPDR) begin
            bsr_q <= ring_s; // RL14 RL17
         end else if (state_q == sjt_pkg::ST_SHDR) begin
            bsr_q <= {tdi_smp_q, bsr_q[sjt_pkg::BSR_LEN-1:1]}; // RL15
         end
      end
   end

   //===========================================================================
   // Last stage of the one register in the path
   always_comb begin
      if (state_q == sjt_pkg::ST_SHIR) begin
         scan_lsb = ir_sh_q[0]; // RL3 RL4
      end else if (sel_id) begin
         scan_lsb = id_sh_q[0]; // RL3 RL4
      end else if (sel_bsr) begin
         scan_lsb = bsr_q[0]; // RL3 RL4
      end else begin
         scan_lsb = byp_q; // RL3 RL4
      end
   end

   // Push one bit per step, a cycle after the registers settle
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         push_q <= 1'b0;
      end else if (proc) begin
         push_q <= 1'b1;
      end else if (buf_in_ready) begin
         push_q <= 1'b0;
      end
   end

   // Buffer drained only on the falling edge, so the launch waits there
   sjt_obuf #(
      .WIDTH (sjt_pkg::BUF_WIDTH),
      .DEPTH (sjt_pkg::BUF_DEPTH)
   ) u_obuf (
      .sys_clk_i   (sys_clk_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (push_q),
      .in_ready_o  (buf_in_ready),
      .in_data_i   ({sjt_pkg::sjt_is_shift(state_q), scan_lsb}), // RL19
      .out_valid_o (buf_out_valid),
      .out_ready_i (tck_fall),
      .out_data_o  (buf_out_data)
   );

   //===========================================================================
   // Output launch on the falling test clock edge
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall && buf_out_valid) begin
         tdo_q    <= buf_out_data[0]; // RL1 RL4
         tdo_oe_q <= buf_out_data[1]; // RL19
      end
   end

   assign tdo_o    = tdo_q;
   assign tdo_oe_o = tdo_oe_q;

   //===========================================================================
   // Helper: consecutive steps taken with mode select high
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tms_ones_q <= '0;
      end else if (proc) begin
         if (!tms_smp_q) begin
            tms_ones_q <= '0;
         end else if (tms_ones_q != sjt_pkg::TMS_RESET_CNT) begin
            tms_ones_q <= 3'(tms_ones_q + 1'b1);
         end
      end
   end

   //===========================================================================
   // Checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   five_ones_reset_a: assert property ( // RL6
      (tms_ones_q == sjt_pkg::TMS_RESET_CNT) |-> (state_q == sjt_pkg::ST_TLR))
      else $error("five high mode selects did not reach reset");

   state_on_rise_a: assert property ( // RL2
      !proc |=> $stable(state_q))
      else $error("controller moved without a test clock step");

   ir_preset_a: assert property ( // RL10
      (state_q == sjt_pkg::ST_TLR) |-> (ir_act_q == sjt_pkg::INS_IDCODE))
      else $error("instruction not preset to identify in reset");

   ir_update_a: assert property ( // RL8
      (proc && state_q == sjt_pkg::ST_UPIR && state_nx != sjt_pkg::ST_TLR)
      |=> (ir_act_q == $past(ir_sh_q)))
      else $error("instruction not applied on update");

   ir_hold_a: assert property ( // RL9
      (proc && state_q != sjt_pkg::ST_CAPIR && state_q != sjt_pkg::ST_SHIR
       && state_nx != sjt_pkg::ST_TLR) |=> $stable(ir_sh_q))
      else $error("instruction register changed while not selected");

   id_capture_a: assert property ( // RL12
      (proc && sel_id && state_q == sjt_pkg::ST_CAPDR) |=> (id_sh_q == ID_CODE))
      else $error("identification code not captured");

   bsr_capture_a: assert property ( // RL14
      (proc && sel_bsr && state_q == sjt_pkg::ST_CAPDR) |=> (bsr_q == $past(ring_s)))
      else $error("boundary register missed the ring values");

   bypass_shift_a: assert property ( // RL11
      (proc && !sel_id && !sel_bsr && state_q == sjt_pkg::ST_SHDR)
      |=> (byp_q == $past(tdi_smp_q)) ##0 (push_q && scan_lsb == byp_q))
      else $error("bypass stage did not pass the input bit");

   launch_on_fall_a: assert property ( // RL1
      $changed(tdo_oe_q) |-> $past(tck_fall))
      else $error("output enable changed away from a falling edge");

   // The launch lands before the next step, so the state is still the one it was pushed from
   oe_shift_only_a: assert property ( // RL19
      (tck_fall && buf_out_valid) |=> (tdo_oe_q == sjt_pkg::sjt_is_shift(state_q)))
      else $error("output driven outside a shift state");

endmodule : sjt_tap

// File: inc/sjt_pkg.sv
// Shared constants, types and decoders of the SRAM boundary-scan test port
//==============================================================================
// What this block does
// [RL1] Sample on test clock rise, launch on fall
// [RL2] Mode select alone steers the controller
// [RL3] Exactly one register between data in/out
// [RL4] Data out shows selected register's last stage
// [RL5] No reset pin; reset via mode select only
// [RL6] Five rising edges with select high reset
// [RL7] Power-up forces the controller into reset
// [RL8] Instruction acts in idle and data states
// [RL9] Instruction register shifts only when selected
// [RL10] Reset and power-up preset identify instruction
// [RL11] Bypass is a single-bit shift stage
// [RL12] Identify captures fixed 32-bit code at capture
// [RL13] Identification register shifts out in shift
// [RL14] Boundary register captures I/O ring at capture
// [RL15] Captured boundary contents shift out in shift
// [RL16] Several instructions select the boundary register
// [RL17] Each boundary bit tied to one bump
// [RL18] Standard sixteen-state controller with both paths
// [RL19] Data out driven only in shift states
package sjt_pkg;

   //===========================================================================
   // Register sizes
   localparam int unsigned IR_W    = 3;
   localparam int unsigned ID_W    = 32;
   localparam int unsigned BSR_LEN = 109;

   //===========================================================================
   // Instruction codes and values after reset or capture
   localparam logic [IR_W-1:0] INS_EXTEST  = 3'h0;
   localparam logic [IR_W-1:0] INS_IDCODE  = 3'h1;
   localparam logic [IR_W-1:0] INS_SAMPLE  = 3'h4;
   localparam logic [IR_W-1:0] INS_PRELOAD = 3'h5;
   localparam logic [IR_W-1:0] INS_BYPASS  = 3'h7;
   localparam logic [IR_W-1:0] IR_CAPTURE  = 3'h1;

   //===========================================================================
   // Counts and buffer shape
   localparam logic [2:0]  TMS_RESET_CNT = 3'h5;
   localparam int unsigned BUF_DEPTH     = 2;
   localparam int unsigned BUF_WIDTH     = 2;

   //===========================================================================
   // Controller states
   typedef enum logic [3:0] {
      ST_TLR   = 4'hf,
      ST_RTI   = 4'hc,
      ST_SELDR = 4'h7,
      ST_CAPDR = 4'h6,
      ST_SHDR  = 4'h2,
      ST_EX1DR = 4'h1,
      ST_PADR  = 4'h3,
      ST_EX2DR = 4'h0,
      ST_UPDR  = 4'h5,
      ST_SELIR = 4'h4,
      ST_CAPIR = 4'he,
      ST_SHIR  = 4'ha,
      ST_EX1IR = 4'h9,
      ST_PAIR  = 4'hb,
      ST_EX2IR = 4'h8,
      ST_UPIR  = 4'hd
   } sjt_state_e;

   // Instructions that place the boundary register in the path
   function automatic logic sjt_sel_bsr(input logic [IR_W-1:0] ins);
      return (ins == INS_EXTEST) || (ins == INS_SAMPLE) || (ins == INS_PRELOAD);
   endfunction : sjt_sel_bsr

   // Shift states are the only ones that drive the data output
   function automatic logic sjt_is_shift(input sjt_state_e st);
      return (st == ST_SHDR) || (st == ST_SHIR);
   endfunction : sjt_is_shift

endpackage : sjt_pkg

// File: core/sjt_sync.sv
// Two-stage synchroniser for levels entering the system clock domain
`timescale 1ns/1ns
module sjt_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             sys_clk_i,
   input  wire logic             arst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   //===========================================================================
   // Per-bit flop pairs; first stage feeds only the second
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= async_i[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   assign sync_o = sync_q;

endmodule : sjt_sync

// File: core/sjt_obuf.sv
// Small FIFO with valid/ready on both sides for launched output bits
`timescale 1ns/1ns
module sjt_obuf #(
   parameter int unsigned WIDTH = 2,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             sys_clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);

   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_ptr_q;
   logic [PW-1:0]    rd_ptr_q;
   logic [CW-1:0]    count_q;
   logic             push;
   logic             pop;

   // Honest full and empty straight from the occupancy count
   assign in_ready_o  = (count_q != CW'(DEPTH));
   assign out_valid_o = (count_q != '0);
   assign out_data_o  = mem_q[rd_ptr_q];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   //===========================================================================
   // Storage and pointers
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
      end else if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_q + 1'b1);
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_q + 1'b1);
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         count_q <= '0;
      end else if (push && !pop) begin
         count_q <= CW'(count_q + 1'b1);
      end else if (pop && !push) begin
         count_q <= CW'(count_q - 1'b1);
      end
   end

   //===========================================================================
   // Occupancy grows by one on a push without a pop
   buf_count_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (push && !pop) |=> (count_q == CW'($past(count_q) + 1'b1)))
      else $error("buffer count did not grow on push");

endmodule : sjt_obuf

// File: tb/sjt_host_model.sv
// Behavioural boundary-scan controller driving the test port pins
`timescale 1ns/1ns
module sjt_host_model (
   input  wire logic sys_clk_i,
   input  wire logic tdo_i,
   input  wire logic tdo_oe_i,
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o
);
   // Test clock rests low outside frames
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end

   //===========================================================================
   // One test clock period of 8 system clocks, 400 ns
   task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
      tms_o <= tms;                  // Changed with the fall, long before the rise
      tdi_o <= tdi;
      repeat (4) @(posedge sys_clk_i);
      tdo = tdo_oe_i ? tdo_i : !tdo_i; // Released pin has no pull, show the inverse
      oe  = tdo_oe_i;
      tck_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      tck_o <= 1'b0;
   endtask : step

   // No reset pin exists, so reset is five rises with mode select high
   task automatic tms_reset();
      logic o;
      logic e;
      repeat (5) step(1'b1, 1'b0, o, e);
   endtask : tms_reset
endmodule : sjt_host_model

// File: tb/testbench.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
module testbench;
   logic                        sys_clk_i;
   logic                        arst_n_i;
   logic                        tck;
   logic                        tms;
   logic                        tdi;
   logic                        tdo_o;
   logic                        tdo_oe_o;
   logic [sjt_pkg::BSR_LEN-1:0] ring_i;
   int                          failures;
   int                          cmp_count;
   int                          cycles;
   localparam logic [31:0] ID_CODE = 32'h1234_5671; // Arbitrary value, bit 0 high

   sjt_tap #(.ID_CODE(ID_CODE)) i_dut (
      .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .tck_i(tck), .tms_i(tms),
      .tdi_i(tdi), .ring_i(ring_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o));
   sjt_host_model i_host (
      .sys_clk_i(sys_clk_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o),
      .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

   //===========================================================================
   // Clock and hang guard
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   //===========================================================================
   // Checking and verdict
   task automatic check(input string name, input logic [108:0] seen, input logic [108:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("failures %0d, comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   // Expected scan-out per instruction; unused codes behave as bypass
   function automatic logic [108:0] f_exp(input logic [2:0] c, input logic [108:0] d,
                                          input logic [108:0] r);
      case (c)
         sjt_pkg::INS_EXTEST, sjt_pkg::INS_SAMPLE, sjt_pkg::INS_PRELOAD: return r;
         sjt_pkg::INS_IDCODE: return {d[76:0], ID_CODE};
         default: return {d[107:0], 1'b0};
      endcase
   endfunction : f_exp

   //===========================================================================
   // Scan from idle back to idle; instruction path when ir is set
   task automatic scan(input bit ir, input int n, input logic [108:0] din,
                       output logic [108:0] dout);
      logic o;
      logic e;
      dout = '0;
      i_host.step(1'b1, 1'b0, o, e);
      if (ir)
         i_host.step(1'b1, 1'b0, o, e);
      i_host.step(1'b0, 1'b0, o, e);
      i_host.step(1'b0, 1'b0, o, e);
      for (int i = 0; i < n; i++) begin
         i_host.step(i == n - 1, din[i], o, e);
         dout[i] = o;
         check("tdo_oe in shift", 109'(e), 109'(1));
      end
      i_host.step(1'b1, 1'b0, o, e);
      i_host.step(1'b0, 1'b0, o, e);
      check("tdo_oe after update", 109'(e), 109'(0));
   endtask : scan

   //===========================================================================
   // Main sequence
   initial begin
      logic [108:0] d;
      logic [108:0] q;
      logic         o;
      logic         e;
      arst_n_i = 1'b0;
      ring_i   = '0;
      void'($urandom(32'hdb63fe61));
      repeat (3) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      check("tdo_oe after reset", 109'(tdo_oe_o), 109'(0));
      i_host.step(1'b0, 1'b0, o, e);
      scan(1'b0, 32, '0, q);
      check("power-up id", q, 109'(ID_CODE));
      // Every instruction code, fresh ring values each time
      for (int c = 0; c < 8; c++) begin
         ring_i <= 109'({$urandom, $urandom, $urandom, $urandom});
         scan(1'b1, 3, 109'(c), q);
         check("ir capture", q, 109'(sjt_pkg::IR_CAPTURE));
         d = 109'({$urandom, $urandom, $urandom, $urandom});
         scan(1'b0, 109, d, q);
         check("dr scan", q, f_exp(3'(c), d, ring_i));
      end
      // Bypass loaded; reset from inside Shift-DR via mode select alone
      i_host.step(1'b1, 1'b0, o, e);
      i_host.step(1'b0, 1'b0, o, e);
      i_host.step(1'b0, 1'b0, o, e);
      i_host.tms_reset();
      i_host.step(1'b0, 1'b0, o, e);
      scan(1'b0, 32, '0, q);
      check("id after tms reset", q, 109'(ID_CODE));
      conclude();
   end
endmodule : testbench
